/* design/spo_pkg.sv */
// package: constants for the safe proportional output supervisor
package spo_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_DITHER = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_OCTRIP = 8'h14;
    localparam logic [7:0] ADDR_LED = 8'h18;
    localparam logic [7:0] ADDR_CURRENT = 8'h1C;
    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OC_CLR = 2;
    localparam int CTRL_APP_RUN = 3;
    localparam int CTRL_DITHER_EN = 4;
    // mode codes
    localparam logic [1:0] MODE_OPEN = 2'h0;
    localparam logic [1:0] MODE_CLOSED = 2'h1;
    // status bit positions
    localparam int ST_OC = 0;
    localparam int ST_OVL = 4;
    localparam int ST_MODE = 5;
    localparam int ST_SAFE = 6;
    localparam int ST_SEC = 7;
    localparam int ST_SUPPLY = 8;
    localparam int ST_RED_FB = 9;
    localparam int ST_OUT_ON = 10;
    // current range in mA
    localparam logic [15:0] CMD_MIN_MA = 16'h000A; // 10 mA
    localparam logic [15:0] CMD_MAX_MA = 16'h0BB8; // 3000 mA
    localparam logic [15:0] TRIP_MIN_MA = 16'h1388; // 5000 mA
    localparam logic [15:0] TRIP_MAX_MA = 16'h1C84; // 7300 mA
    // reset values
    localparam logic [15:0] PERIOD_RST = 16'h2710; // 1 kHz at 10 MHz
    localparam logic [15:0] TRIP_RST = 16'h1388;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int HOLD_MS = 250;
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
endpackage

/* design/spo_supervisor.sv */
// supervisor for one proportional output channel with safety switch and led arbitration
//
// Behaviour
// - latch output off above over-current trip
// - software clears over-current latch, output retries
// - command accepts 10 to 3000 mA
// - conducts only while redundant switch enabled
// - hold redundant switch off 250 ms
// - redundant switch feedback presented to secondary
// - primary sees own switch via current feedback
// - overload sets bit 4, 250 ms off clears
// - invalid mode sets bit 5 until valid
// - safety failure sets bit 6 permanently
// - secondary off sets bit 7, recovery conditions
// - supply fault sets bit 8, clears conditionally
// - green on, red off until application runs
// - yellow colours driven by low-level logic only
// - yellow overrides shared green or red
// - open loop duty and closed loop current
// - closed loop latch released only at zero command
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module spo_supervisor #(
    parameter int HOLD_CYCLES = spo_pkg::HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic sec_enable_req,
    input wire logic sec_safety_fail,
    input wire logic supply_ok,
    input wire logic overload,
    input wire logic [15:0] current_ma,
    input wire logic yellow_primary,
    input wire logic yellow_secondary,
    output logic primary_switch,
    output logic redundant_switch,
    output logic redundant_fb,
    output logic led_green,
    output logic led_red,
    output logic led_yellow_g,
    output logic led_yellow_r
);
    // pin synchronisers: three stages, change counts when stages 2 and 3 agree
    logic [2:0] sen_s, sfail_s, sup_s, ovl_s, yp_s, ys_s;
    logic sen_q, sfail_q, sup_q, ovl_q, yp_q, ys_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sen_s <= 3'h0;
            sfail_s <= 3'h0;
            sup_s <= 3'h7;
            ovl_s <= 3'h0;
            yp_s <= 3'h0;
            ys_s <= 3'h0;
        end else begin
            sen_s <= {sen_s[1:0], sec_enable_req};
            sfail_s <= {sfail_s[1:0], sec_safety_fail};
            sup_s <= {sup_s[1:0], supply_ok};
            ovl_s <= {ovl_s[1:0], overload};
            yp_s <= {yp_s[1:0], yellow_primary};
            ys_s <= {ys_s[1:0], yellow_secondary};
        end
    end
    // filtered levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sen_q <= 1'b0;
            sfail_q <= 1'b0;
            sup_q <= 1'b1;
            ovl_q <= 1'b0;
            yp_q <= 1'b0;
            ys_q <= 1'b0;
        end else begin
            if (sen_s[2] == sen_s[1]) sen_q <= sen_s[2];
            if (sfail_s[2] == sfail_s[1]) sfail_q <= sfail_s[2];
            if (sup_s[2] == sup_s[1]) sup_q <= sup_s[2];
            if (ovl_s[2] == ovl_s[1]) ovl_q <= ovl_s[2];
            if (yp_s[2] == yp_s[1]) yp_q <= yp_s[2];
            if (ys_s[2] == ys_s[1]) ys_q <= ys_s[2];
        end
    end
    // current sample is a multi-bit bus; registered twice, used only as a magnitude
    logic [15:0] cur_a_r, cur_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_a_r <= 16'h0000;
            cur_r <= 16'h0000;
        end else begin
            cur_a_r <= current_ma;
            cur_r <= cur_a_r;
        end
    end

    // software registers
    logic [1:0] mode_r;
    logic app_run_r, dither_en_r;
    logic [15:0] cmd_r, period_r, trip_r;
    logic [7:0] dith_step_r, dith_amp_r;
    logic [3:0] led_app_r;
    logic wr_ctrl, wr_cmd, oc_clr;
    assign wr_ctrl = wr && (addr == spo_pkg::ADDR_CTRL);
    assign wr_cmd = wr && (addr == spo_pkg::ADDR_CMD);
    assign oc_clr = wr_ctrl && wdata[spo_pkg::CTRL_OC_CLR];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= spo_pkg::MODE_OPEN;
            app_run_r <= 1'b0;
            dither_en_r <= 1'b0;
            cmd_r <= 16'h0000;
            period_r <= spo_pkg::PERIOD_RST;
            trip_r <= spo_pkg::TRIP_RST;
            dith_step_r <= 8'h00;
            dith_amp_r <= 8'h00;
            led_app_r <= 4'h0;
        end else if (wr) begin
            case (addr)
                spo_pkg::ADDR_CTRL: begin
                    mode_r <= wdata[spo_pkg::CTRL_MODE_LSB +: 2];
                    app_run_r <= app_run_r | wdata[spo_pkg::CTRL_APP_RUN];
                    dither_en_r <= wdata[spo_pkg::CTRL_DITHER_EN];
                end
                // command clamped to the supported full-scale range, zero kept as off
                spo_pkg::ADDR_CMD: begin
                    if (wdata[15:0] == 16'h0000) cmd_r <= 16'h0000;
                    else if (wdata[15:0] < spo_pkg::CMD_MIN_MA) cmd_r <= spo_pkg::CMD_MIN_MA;
                    else if (wdata[15:0] > spo_pkg::CMD_MAX_MA) cmd_r <= spo_pkg::CMD_MAX_MA;
                    else cmd_r <= wdata[15:0];
                end
                spo_pkg::ADDR_PERIOD: period_r <= (wdata[15:0] < 16'h0002) ? 16'h0002 : wdata[15:0];
                spo_pkg::ADDR_DITHER: begin
                    dith_step_r <= wdata[7:0];
                    dith_amp_r <= wdata[15:8];
                end
                spo_pkg::ADDR_OCTRIP: begin
                    if (wdata[15:0] < spo_pkg::TRIP_MIN_MA) trip_r <= spo_pkg::TRIP_MIN_MA;
                    else if (wdata[15:0] > spo_pkg::TRIP_MAX_MA) trip_r <= spo_pkg::TRIP_MAX_MA;
                    else trip_r <= wdata[15:0];
                end
                spo_pkg::ADDR_LED: led_app_r <= wdata[3:0]; // only green and red; yellow not writable
                default: ;
            endcase
        end
    end

    logic mode_ok, cmd_off;
    assign mode_ok = (mode_r == spo_pkg::MODE_OPEN) || (mode_r == spo_pkg::MODE_CLOSED);
    assign cmd_off = (cmd_r == 16'h0000);

    // over-current latch: set wins over clear; closed loop needs zero command to release
    logic oc_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) oc_r <= 1'b0;
        else if (cur_r > trip_r) oc_r <= 1'b1;
        else if (oc_clr && (mode_r != spo_pkg::MODE_CLOSED || cmd_off)) oc_r <= 1'b0;
    end

    // overload: disabled, needs command off for a full hold before clearing
    logic ovl_r;
    logic [31:0] ovl_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovl_r <= 1'b0;
            ovl_cnt_r <= 32'h0000_0000;
        end else if (ovl_q) begin
            ovl_r <= 1'b1;
            ovl_cnt_r <= 32'h0000_0000;
        end else if (ovl_r) begin
            if (!cmd_off) ovl_cnt_r <= 32'h0000_0000;
            else if (ovl_cnt_r >= 32'(HOLD_CYCLES - 1)) ovl_r <= 1'b0;
            else ovl_cnt_r <= ovl_cnt_r + 32'h0000_0001;
        end
    end

    // invalid mode flag follows mode validity
    logic mode_err_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) mode_err_r <= 1'b0;
        else if (!mode_ok) mode_err_r <= 1'b1;
        else mode_err_r <= 1'b0;
    end

    // safety failure sticks until reset, software cannot touch it
    logic safe_fail_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) safe_fail_r <= 1'b0;
        else if (sfail_q) safe_fail_r <= 1'b1;
    end

    // supply fault clears only with supply back and command off
    logic sup_err_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sup_err_r <= 1'b0;
        else if (!sup_q) sup_err_r <= 1'b1;
        else if (cmd_off) sup_err_r <= 1'b0;
    end

    // redundant switch: secondary opens at will, re-enable after hold and command off
    logic red_r, sec_off_r;
    logic [31:0] red_cnt_r;
    logic hold_done;
    assign hold_done = (red_cnt_r >= 32'(HOLD_CYCLES));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            red_r <= 1'b0;
            sec_off_r <= 1'b0;
            red_cnt_r <= 32'(HOLD_CYCLES);
        end else if (!sen_q || safe_fail_r) begin
            if (red_r) begin
                sec_off_r <= 1'b1;
                red_cnt_r <= 32'h0000_0000;
            end else if (!hold_done) begin
                red_cnt_r <= red_cnt_r + 32'h0000_0001;
            end
            red_r <= 1'b0;
        end else if (!red_r) begin
            if (!hold_done) red_cnt_r <= red_cnt_r + 32'h0000_0001;
            else if (!sec_off_r || cmd_off) begin
                red_r <= 1'b1;
                sec_off_r <= 1'b0;
            end
        end
    end

    // dither: triangle offset stepped at programmed rate
    logic [15:0] dith_div_r;
    logic [7:0] dith_val_r;
    logic dith_up_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dith_div_r <= 16'h0000;
            dith_val_r <= 8'h00;
            dith_up_r <= 1'b1;
        end else if (dith_div_r >= {dith_step_r, 8'h00}) begin
            dith_div_r <= 16'h0000;
            if (dith_up_r && dith_val_r >= dith_amp_r) dith_up_r <= 1'b0;
            else if (!dith_up_r && dith_val_r == 8'h00) dith_up_r <= 1'b1;
            else dith_val_r <= dith_up_r ? dith_val_r + 8'h01 : dith_val_r - 8'h01;
        end else begin
            dith_div_r <= dith_div_r + 16'h0001;
        end
    end

    // command with dither; dither is suppressed while the command is zero
    logic [16:0] eff_cmd;
    assign eff_cmd = (dither_en_r && !cmd_off) ? {1'b0, cmd_r} + {9'h000, dith_val_r} : {1'b0, cmd_r};

    // closed loop: integrate current error into duty (mA scaled to full range)
    logic [15:0] duty_cl_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) duty_cl_r <= 16'h0000;
        else if (mode_r != spo_pkg::MODE_CLOSED || cmd_off) duty_cl_r <= 16'h0000;
        else if ({1'b0, cur_r} < eff_cmd && duty_cl_r < 16'hFFFF) duty_cl_r <= duty_cl_r + 16'h0001;
        else if ({1'b0, cur_r} > eff_cmd && duty_cl_r != 16'h0000) duty_cl_r <= duty_cl_r - 16'h0001;
    end

    // open loop: command is duty in parts-of-3000 units mapped onto the period
    logic [31:0] duty_prod;
    logic [15:0] duty_ol, duty_sel, cmp;
    assign duty_prod = {16'h0000, (eff_cmd > {1'b0, spo_pkg::CMD_MAX_MA}) ? spo_pkg::CMD_MAX_MA : eff_cmd[15:0]}
                       * {16'h0000, period_r};
    assign duty_ol = 16'(duty_prod / 32'(spo_pkg::CMD_MAX_MA));
    assign duty_sel = (mode_r == spo_pkg::MODE_CLOSED) ? duty_cl_r : duty_ol;
    assign cmp = (mode_r == spo_pkg::MODE_CLOSED) ? 16'(({16'h0000, duty_sel} * {16'h0000, period_r}) >> 16) : duty_sel;

    // pwm counter
    logic [15:0] pwm_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pwm_cnt_r <= 16'h0000;
        else if (pwm_cnt_r >= period_r - 16'h0001) pwm_cnt_r <= 16'h0000;
        else pwm_cnt_r <= pwm_cnt_r + 16'h0001;
    end

    // drive enable: any fault keeps the primary switch open
    logic drive_ok;
    assign drive_ok = !oc_r && !ovl_r && mode_ok && !safe_fail_r && !sup_err_r && !cmd_off;

    // outputs, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            primary_switch <= 1'b0;
            redundant_switch <= 1'b0;
            redundant_fb <= 1'b0;
        end else begin
            primary_switch <= drive_ok && red_r && (pwm_cnt_r < cmp);
            redundant_switch <= red_r;
            redundant_fb <= red_r;
        end
    end

    // leds: boot default until app runs, yellow overrides shared colour
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_green <= 1'b1;
            led_red <= 1'b0;
            led_yellow_g <= 1'b0;
            led_yellow_r <= 1'b0;
        end else begin
            led_yellow_g <= yp_q;
            led_yellow_r <= ys_q;
            led_green <= !yp_q && (app_run_r ? led_app_r[0] : 1'b1);
            led_red <= !ys_q && (app_run_r ? led_app_r[1] : 1'b0);
        end
    end

    // read port; current readback lets the primary see its own switch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rdata <= 32'h0000_0000;
        else if (rd) begin
            case (addr)
                spo_pkg::ADDR_CTRL: rdata <= {27'h0, dither_en_r, app_run_r, 1'b0, mode_r};
                spo_pkg::ADDR_CMD: rdata <= {16'h0000, cmd_r};
                spo_pkg::ADDR_PERIOD: rdata <= {16'h0000, period_r};
                spo_pkg::ADDR_DITHER: rdata <= {16'h0000, dith_amp_r, dith_step_r};
                spo_pkg::ADDR_STATUS: rdata <= {21'h0, primary_switch, red_r, sup_err_r, sec_off_r, safe_fail_r,
                                                mode_err_r, ovl_r, 3'h0, oc_r};
                spo_pkg::ADDR_OCTRIP: rdata <= {16'h0000, trip_r};
                spo_pkg::ADDR_LED: rdata <= {28'h0, led_app_r};
                spo_pkg::ADDR_CURRENT: rdata <= {16'h0000, cur_r};
                default: rdata <= 32'h0000_0000;
            endcase
        end else rdata <= 32'h0000_0000;
    end
endmodule

/* bench/spo_load_model.sv */
// partner: half-bridge stage and valve coil load behind the supervised output
`timescale 1ns/100ps
module spo_load_model (
    input wire logic clk,
    input wire logic primary_switch,
    input wire logic redundant_switch,
    input wire logic short_fault,
    output logic [15:0] current_ma
);
    logic [3:0] decay_r = 4'h0;
    logic [15:0] level_r = 16'h0000;
    // supply reaches the coil only through both series switches; a short pulls far above trip
    always_ff @(posedge clk) begin
        if (primary_switch && redundant_switch) begin
            level_r <= short_fault ? 16'h2000 : 16'h05DC;
            decay_r <= 4'h8;
        end else if (decay_r != 4'h0) begin
            decay_r <= decay_r - 4'h1;
        end
    end
    // coil freewheels a few cycles after the stage opens, so a short stays visible for a while
    assign current_ma = (decay_r != 4'h0) ? level_r : 16'h0000;
endmodule

/* bench/spo_supervisor_monitor.sv */
// checker: port-level assertions for the proportional output supervisor
`timescale 1ns/100ps
module spo_supervisor_monitor #(
    parameter int HOLD_CYCLES = spo_pkg::HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [15:0] current_ma,
    input wire logic yellow_primary,
    input wire logic yellow_secondary,
    input wire logic primary_switch,
    input wire logic redundant_switch,
    input wire logic redundant_fb,
    input wire logic led_green,
    input wire logic led_red,
    input wire logic led_yellow_g,
    input wire logic led_yellow_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic app_r;
    logic st_rd_r;
    logic safe_r;
    int off_cnt_r;
    // mirror of the sticky application-running flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            app_r <= 1'b0;
        end else if (wr && addr == spo_pkg::ADDR_CTRL && wdata[spo_pkg::CTRL_APP_RUN]) begin
            app_r <= 1'b1;
        end
    end
    // remember any status read that showed the safety failure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_rd_r <= 1'b0;
            safe_r <= 1'b0;
        end else begin
            st_rd_r <= rd && addr == spo_pkg::ADDR_STATUS;
            safe_r <= safe_r || (st_rd_r && rdata[spo_pkg::ST_SAFE]);
        end
    end
    // cycles the redundant switch has been open; starts saturated as reset counts as done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_cnt_r <= HOLD_CYCLES;
        end else if (redundant_switch) begin
            off_cnt_r <= 0;
        end else if (off_cnt_r < HOLD_CYCLES) begin
            off_cnt_r <= off_cnt_r + 1;
        end
    end
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_green_boot: assert property (!app_r && !led_yellow_g |-> led_green && !led_red)
        else $error("boot indicator pattern lost");
    a_yellow_green: assert property (led_yellow_g |-> !led_green)
        else $error("green lit under yellow");
    a_yellow_red: assert property (led_yellow_r |-> !led_red)
        else $error("red lit under yellow");
    a_yellow_g_follow: assert property (yellow_primary [*8] |-> led_yellow_g)
        else $error("primary yellow not shown");
    a_yellow_r_follow: assert property (yellow_secondary [*8] |-> led_yellow_r)
        else $error("secondary yellow not shown");
    a_conduct_gate: assert property (!redundant_switch [*2] |-> !primary_switch)
        else $error("primary conducts with redundant switch open");
    a_fb_follow: assert property ($stable(redundant_switch) [*2] |-> redundant_fb == redundant_switch)
        else $error("feedback differs from redundant switch");
    a_hold_off: assert property ($rose(redundant_switch) |-> off_cnt_r >= HOLD_CYCLES)
        else $error("redundant switch closed before hold-off ended");
    a_trip_off: assert property ((current_ma > spo_pkg::TRIP_MAX_MA) [*6] |-> !primary_switch)
        else $error("output still driven above trip");
    a_safe_sticky: assert property (st_rd_r && safe_r |-> rdata[spo_pkg::ST_SAFE])
        else $error("safety failure bit cleared");
    c_reenable: cover property ($rose(redundant_switch));
    c_trip: cover property ((current_ma > spo_pkg::TRIP_MAX_MA) [*6]);
    c_safe: cover property (safe_r);
endmodule
bind spo_supervisor spo_supervisor_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.*);

/* bench/testbench.sv */
// testbench: random and directed checks of the proportional output supervisor
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
`define WAITC(c) for (k = 0; k < 300 && !(c); k++) begin @(posedge clk); #1; end
module testbench;
    localparam int HOLD = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sec_enable_req = 1'b0;
    logic sec_safety_fail = 1'b0;
    logic supply_ok = 1'b1;
    logic overload = 1'b0;
    logic yellow_primary = 1'b0;
    logic yellow_secondary = 1'b0;
    logic short_fault = 1'b0;
    logic [15:0] current_ma;
    logic [31:0] rdata;
    logic primary_switch, redundant_switch, redundant_fb, led_green, led_red, led_yellow_g, led_yellow_r;
    logic [31:0] seed = 32'h0001_391C;
    logic [31:0] v;
    logic [15:0] c;
    logic [15:0] corner [4] = '{16'h0009, 16'h000A, 16'h0BB8, 16'h0BB9};
    int k;
    int bad_count = 0;
    int n_compared = 0;
    spo_supervisor #(.HOLD_CYCLES(HOLD)) u_dut (.*);
    spo_load_model u_load (.*);
    // free-running system clock
    always #50 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // expected command readback after range limiting
    function automatic logic [31:0] clamp(input logic [15:0] m);
        if (m == 16'h0000) return 32'h0000_0000;
        if (m < spo_pkg::CMD_MIN_MA) return {16'h0000, spo_pkg::CMD_MIN_MA};
        if (m > spo_pkg::CMD_MAX_MA) return {16'h0000, spo_pkg::CMD_MAX_MA};
        return {16'h0000, m};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_bit(input int b, input logic e);
        logic [31:0] d;
        int i;
        d = 32'h0000_0000;
        for (i = 0; i < 150; i++) begin
            rreg(spo_pkg::ADDR_STATUS, d);
            if (d[b] === e) break;
        end
        `CHK(d[b], e)
    endtask
    // true if the primary switch closed at any point over n cycles
    task automatic seen_on(input int n, output logic s);
        s = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            s = s | primary_switch;
        end
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, far beyond the few thousand cycles the sequence needs
    initial begin
        #5_000_000;
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK({led_green, led_red}, 2'b10)
        rreg(spo_pkg::ADDR_PERIOD, v);
        `CHK(v, {16'h0000, spo_pkg::PERIOD_RST})
        rreg(8'h40, v);
        `CHK(v, 32'h0000_0000)
        rreg(spo_pkg::ADDR_OCTRIP, v);
        `CHK(v, {16'h0000, spo_pkg::TRIP_RST})
        wreg(spo_pkg::ADDR_OCTRIP, 32'h0000_2000);
        rreg(spo_pkg::ADDR_OCTRIP, v);
        `CHK(v, {16'h0000, spo_pkg::TRIP_MAX_MA})
        @(posedge clk) yellow_primary <= 1'b1;
        cyc(10);
        `CHK({led_yellow_g, led_green}, 2'b10)
        @(posedge clk) yellow_primary <= 1'b0;
        wreg(spo_pkg::ADDR_LED, 32'hFFFF_FFFF);
        cyc(10);
        `CHK({led_yellow_g, led_yellow_r, led_green, led_red}, 4'b0010)
        // corner commands first, then random ones
        for (int j = 0; j < 10; j++) begin
            seed = xs(seed);
            c = (j < 4) ? corner[j] : {3'h0, seed[12:0]};
            wreg(spo_pkg::ADDR_CMD, {16'h0000, c});
            rreg(spo_pkg::ADDR_CMD, v);
            `CHK(v, clamp(c))
        end
        for (int j = 2; j < 4; j++) begin
            wreg(spo_pkg::ADDR_CTRL, 32'(j));
            wait_bit(spo_pkg::ST_MODE, 1'b1);
            wreg(spo_pkg::ADDR_CTRL, 32'h0000_0000);
            wait_bit(spo_pkg::ST_MODE, 1'b0);
        end
        wreg(spo_pkg::ADDR_PERIOD, 32'h0000_0014);
        @(posedge clk) sec_enable_req <= 1'b1;
        wreg(spo_pkg::ADDR_CMD, 32'h0000_05DC);
        `WAITC(primary_switch === 1'b1)
        `CHK({primary_switch, redundant_switch, redundant_fb}, 3'b111)
        // the coil current passes two sampling stages, so only the second read is sure to show it
        rreg(spo_pkg::ADDR_CURRENT, v);
        rreg(spo_pkg::ADDR_CURRENT, v);
        `CHK(v, 32'h0000_05DC)
        // open loop short: trips, stays off, software clear resumes drive
        @(posedge clk) short_fault <= 1'b1;
        wait_bit(spo_pkg::ST_OC, 1'b1);
        @(posedge clk) short_fault <= 1'b0;
        seen_on(20, v[0]);
        `CHK(v[0], 1'b0)
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_0004);
        wait_bit(spo_pkg::ST_OC, 1'b0);
        `WAITC(primary_switch === 1'b1)
        `CHK(primary_switch, 1'b1)
        // closed loop short: clear refused until the command is zero
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_0001);
        // the integrator climbs one step a cycle; about 3300 steps give the first on pulse at period 20
        cyc(3300);
        `WAITC(primary_switch === 1'b1)
        `CHK(primary_switch, 1'b1)
        @(posedge clk) short_fault <= 1'b1;
        wait_bit(spo_pkg::ST_OC, 1'b1);
        @(posedge clk) short_fault <= 1'b0;
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_0005);
        cyc(5);
        rreg(spo_pkg::ADDR_STATUS, v);
        `CHK(v[spo_pkg::ST_OC], 1'b1)
        wreg(spo_pkg::ADDR_CMD, 32'h0000_0000);
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_0005);
        wait_bit(spo_pkg::ST_OC, 1'b0);
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_0000);
        wreg(spo_pkg::ADDR_CMD, 32'h0000_05DC);
        @(posedge clk) overload <= 1'b1;
        wait_bit(spo_pkg::ST_OVL, 1'b1);
        seen_on(20, v[0]);
        `CHK(v[0], 1'b0)
        @(posedge clk) overload <= 1'b0;
        wreg(spo_pkg::ADDR_CMD, 32'h0000_0000);
        cyc(20);
        rreg(spo_pkg::ADDR_STATUS, v);
        `CHK(v[spo_pkg::ST_OVL], 1'b1)
        wait_bit(spo_pkg::ST_OVL, 1'b0);
        wreg(spo_pkg::ADDR_CMD, 32'h0000_05DC);
        @(posedge clk) supply_ok <= 1'b0;
        wait_bit(spo_pkg::ST_SUPPLY, 1'b1);
        @(posedge clk) supply_ok <= 1'b1;
        cyc(20);
        rreg(spo_pkg::ADDR_STATUS, v);
        `CHK(v[spo_pkg::ST_SUPPLY], 1'b1)
        wreg(spo_pkg::ADDR_CMD, 32'h0000_0000);
        wait_bit(spo_pkg::ST_SUPPLY, 0);
        // secondary opens while driving; re-close needs hold-off and a zero command
        wreg(spo_pkg::ADDR_CMD, 32'h0000_05DC);
        `WAITC(primary_switch === 1'b1)
        @(posedge clk) sec_enable_req <= 1'b0;
        wait_bit(spo_pkg::ST_SEC, 1'b1);
        @(posedge clk) sec_enable_req <= 1'b1;
        cyc(2 * HOLD);
        `CHK(redundant_switch, 1'b0)
        wreg(spo_pkg::ADDR_CMD, 32'h0000_0000);
        `WAITC(redundant_switch === 1'b1)
        `CHK(redundant_switch, 1'b1)
        @(posedge clk) sec_enable_req <= 1'b0;
        cyc(8);
        @(posedge clk) sec_enable_req <= 1'b1;
        cyc(HOLD - 20);
        `CHK(redundant_switch, 1'b0)
        `WAITC(redundant_switch === 1'b1)
        `CHK(redundant_switch, 1'b1)
        wreg(spo_pkg::ADDR_DITHER, 32'h0000_0A01);
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_0018);
        wreg(spo_pkg::ADDR_LED, 32'h0000_0002);
        cyc(4);
        `CHK({led_green, led_red}, 2'b01)
        @(posedge clk) yellow_secondary <= 1'b1;
        cyc(10);
        `CHK({led_yellow_r, led_red}, 2'b10)
        @(posedge clk) yellow_secondary <= 1'b0;
        @(posedge clk) sec_safety_fail <= 1'b1;
        wait_bit(spo_pkg::ST_SAFE, 1'b1);
        @(posedge clk) sec_safety_fail <= 1'b0;
        wreg(spo_pkg::ADDR_CTRL, 32'h0000_001C);
        wreg(spo_pkg::ADDR_STATUS, 32'h0000_FFFF);
        cyc(10);
        rreg(spo_pkg::ADDR_STATUS, v);
        `CHK(v[spo_pkg::ST_SAFE], 1'b1)
        end_sim;
    end
endmodule
